// ==== src/ihbi_pkg.sv ====
// Constants and types shared by the ISA host bus interface.
// Assumes a single 10 MHz core clock and pins sampled through synchronisers.
package ihbi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_MIN_NS    = 800;
  localparam int RST_MIN_CYC_I =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W     = 4;
  localparam logic [RST_CNT_W-1:0] RST_MIN_CYC = RST_CNT_W'(RST_MIN_CYC_I);

  // ----------------------------------------------------------------
  // Field positions of the synchronised pin vector
  // ----------------------------------------------------------------
  localparam int PIN_AEN    = 0;
  localparam int PIN_IOR    = 1;
  localparam int PIN_IOW    = 2;
  localparam int PIN_MEMR   = 3;
  localparam int PIN_MEMW   = 4;
  localparam int PIN_SLOT   = 5;
  localparam int PIN_SA_LSB = 6;
  localparam int SA_W       = 20;
  localparam int PIN_IRQ_LSB = PIN_SA_LSB + SA_W;
  localparam int IRQ_N      = 8;
  localparam int PIN_SD_LSB = PIN_IRQ_LSB + IRQ_N;
  localparam int SD_W       = 16;
  localparam int PIN_W      = PIN_SD_LSB + SD_W;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam logic [11:0] PNP_ADDR_PORT = 12'h279;
  localparam logic [11:0] PNP_DATA_PORT = 12'hA79;
  localparam int          IO_WIN_LSB    = 5;
  localparam logic [1:0]  IO16_OFS      = 2'h2;
  localparam int          BROM_LSB      = 14;
  localparam int          BROM_W        = 6;

  // System interrupt level of each request line, line 0 first
  localparam logic [3:0] IRQ_LEVEL [0:IRQ_N-1] =
    '{4'h9, 4'h3, 4'h4, 4'h5, 4'hA, 4'hB, 4'hC, 4'hF};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'(5'h1F);
  localparam logic [7:0]       IRQ_OE_RST = 8'h01;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RF_IDLE,
    RF_COUNT,
    RF_ACTIVE
  } ihbi_rf_e;

  typedef struct packed {
    logic                 s1;
    logic                 s2;
    logic                 s3;
    logic                 flt;
    logic [RST_CNT_W-1:0] cnt;
    ihbi_rf_e             st;
    logic                 active;
    logic                 release_p;
  } ihbi_rf_s;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] flt;
    logic             ior_prev;
    logic             iow_prev;
    logic             memw_prev;
    logic             is16;
    logic [IRQ_N-1:0] irq_drive;
    logic [IRQ_N-1:0] irq_oe;
    logic [3:0]       irq_level;
    logic [IRQ_N-1:0] irq_mon;
    logic             od_level;
    logic             chrdy_oe;
    logic             xfer16_oe;
    logic [SD_W-1:0]  sd_drive;
    logic             sd_oe_lo;
    logic             sd_oe_hi;
    logic             bms_n;
    logic             io_rd;
    logic             io_wr;
    logic             pnp_addr_wr;
    logic             pnp_data_wr;
    logic             flash_wr;
    logic [SA_W-1:0]  addr;
    logic [SD_W-1:0]  wdata;
  } ihbi_state_s;

endpackage

// ==== src/ihbi_rst_if.sv ====
// Carries the filtered bus reset from the pulse filter to the bus core.
// Both ends run on the same core clock.
`timescale 1ns/1ps
interface ihbi_rst_if;
  logic bus_rst_active;
  logic bus_rst_release;

  modport filt (output bus_rst_active, output bus_rst_release);
  modport core (input  bus_rst_active, input  bus_rst_release);
endinterface

// ==== src/ihbi_rst_filter.sv ====
// Bus reset pulse filter: synchronises the ISA reset pin and qualifies it.
// Assumes the pin is asynchronous to the core clock.
`timescale 1ns/1ps
module ihbi_rst_filter
  import ihbi_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic bus_reset,
  ihbi_rst_if.filt  rst
);
  import ihbi_pkg::*;

  ihbi_rf_s r_reg;
  ihbi_rf_s r_next;

  // ----------------------------------------------------------------
  // Pulse qualification
  // ----------------------------------------------------------------
  always_comb begin
    r_next           = r_reg;
    r_next.s1        = bus_reset;
    r_next.s2        = r_reg.s1;
    r_next.s3        = r_reg.s2;
    if (r_reg.s2 == r_reg.s3) begin
      r_next.flt = r_reg.s2;
    end
    r_next.release_p = 1'b0;
    case (r_reg.st)
      RF_IDLE: begin
        if (r_reg.flt) begin
          r_next.st  = RF_COUNT;
          r_next.cnt = RST_CNT_W'(1);
        end
      end
      RF_COUNT: begin
        // A pulse that drops before the minimum width leaves no trace
        if (!r_reg.flt) begin
          r_next.st = RF_IDLE;
        end else if (r_reg.cnt == RST_MIN_CYC - RST_CNT_W'(1)) begin // RULE_09
          r_next.st     = RF_ACTIVE;
          r_next.active = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + RST_CNT_W'(1);
        end
      end
      RF_ACTIVE: begin
        if (!r_reg.flt) begin
          r_next.st        = RF_IDLE;
          r_next.active    = 1'b0;
          r_next.release_p = 1'b1;
        end
      end
      default: begin
        r_next.st = RF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, flt: 1'b0,
                 cnt: '0, st: RF_IDLE, active: 1'b0, release_p: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign rst.bus_rst_active  = r_reg.active;
  assign rst.bus_rst_release = r_reg.release_p;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rst_min_width: assert property ( // RULE_09
    @(posedge clock) disable iff (!nrst)
    $rose(r_reg.active) |-> $past(r_reg.flt) &&
      ($past(r_reg.cnt) == RST_MIN_CYC - RST_CNT_W'(1)))
    else $error("Bus reset taken before minimum width");

  a_rst_short_drop: assert property ( // RULE_09
    @(posedge clock) disable iff (!nrst)
    (r_reg.st == RF_COUNT && !r_reg.flt) |=> !r_reg.active)
    else $error("Short bus reset pulse was not ignored");

  c_rst_taken: cover property (
    @(posedge clock) disable iff (!nrst) $fell(r_reg.active));
endmodule

// ==== src/ihbi_core.sv ====
// ISA host bus interface: command qualification, interrupt lines, wait
// states, slot sensing, 16-bit indication, reset filter, memory decode.
// Assumes all bus pins are asynchronous and the core answers via ready.
`timescale 1ns/1ps

// What this block does, and what it expects of the host
// (RULE_01) I/O commands count only while address enable low
// (RULE_02) Eight request lines mapped to levels 15..2/9
// (RULE_03) One selected line drives, others stay released
// (RULE_04) All request lines monitored for conflicts
// (RULE_05) Channel ready pulled low while core busy
// (RULE_06) Slot width latched when bus reset ends
// (RULE_07) Same pin then signals 16-bit transfers, open drain
// (RULE_08) 16-bit indication decoded without waiting for strobes
// (RULE_09) Bus reset high pulses under 800 ns ignored
// (RULE_10) Plug-and-play ports fully decoded, bit 10 zero
// (RULE_11) Memory write strobe makes flash write commands
// (RULE_12) Boot memory select on base match and strobe
// (RULE_13) Eight-bit slot: low byte only, no indication
// (RULE_14) Host keeps ISA ordering and waits on ready
module ihbi_core
  import ihbi_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   bus_reset,
  input  wire logic                   aen,
  input  wire logic                   ior_n,
  input  wire logic                   iow_n,
  input  wire logic                   smemr_n,
  input  wire logic                   smemw_n,
  input  wire logic [ihbi_pkg::SA_W-1:0]  sa,
  input  wire logic [ihbi_pkg::SD_W-1:0]  sd_level,
  output logic      [ihbi_pkg::SD_W-1:0]  sd_drive,
  output logic                        sd_oe_lo,
  output logic                        sd_oe_hi,
  input  wire logic [ihbi_pkg::IRQ_N-1:0] irq_out_lines_level,
  output logic      [ihbi_pkg::IRQ_N-1:0] irq_out_lines,
  output logic      [ihbi_pkg::IRQ_N-1:0] irq_out_lines_oe,
  output logic                        chrdy_drive,
  output logic                        chrdy_oe,
  input  wire logic                   slot_width_sense,
  output logic                        xfer16_drive,
  output logic                        xfer16_oe,
  output logic                        boot_mem_select_n,
  input  wire logic [9:0]             io_base,
  input  wire logic [ihbi_pkg::BROM_W-1:0] brom_base,
  input  wire logic                   flash_wr_en,
  input  wire logic [2:0]             irq_select,
  input  wire logic                   irq_request,
  input  wire logic                   core_ready,
  input  wire logic [ihbi_pkg::SD_W-1:0]  rd_data,
  output logic                        io_rd_pulse,
  output logic                        io_wr_pulse,
  output logic                        pnp_addr_wr,
  output logic                        pnp_data_wr,
  output logic                        flash_wr_pulse,
  output logic      [ihbi_pkg::SA_W-1:0]  host_addr,
  output logic      [ihbi_pkg::SD_W-1:0]  host_wdata,
  output logic      [ihbi_pkg::IRQ_N-1:0] irq_line_monitor,
  output logic      [3:0]             irq_level,
  output logic                        slot_is_16,
  output logic                        bus_reset_active
);
  import ihbi_pkg::*;

  ihbi_state_s r_reg;
  ihbi_state_s r_next;
  ihbi_rst_if  rst_if ();

  // ----------------------------------------------------------------
  // Reset pulse filter
  // ----------------------------------------------------------------
  ihbi_rst_filter u_rst_filter (
    .clock     (clock),
    .nrst      (nrst),
    .bus_reset (bus_reset),
    .rst       (rst_if)
  );

  // ----------------------------------------------------------------
  // Decode of the filtered pins
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_now;
  logic [SA_W-1:0]  f_sa;
  logic [SD_W-1:0]  f_sd;
  logic             aen_ok;
  logic             ior_act;
  logic             iow_act;
  logic             memr_act;
  logic             memw_act;
  logic             io_hit;
  logic             io16_hit;
  logic             mem_hit;
  logic             pnp_a_hit;
  logic             pnp_d_hit;

  assign pins_now = {sd_level, irq_out_lines_level, sa, slot_width_sense,
                     smemw_n, smemr_n, iow_n, ior_n, aen};
  assign f_sa     = r_reg.flt[PIN_SA_LSB +: SA_W];
  assign f_sd     = r_reg.flt[PIN_SD_LSB +: SD_W];
  assign aen_ok   = !r_reg.flt[PIN_AEN]; // RULE_01
  assign ior_act  = !r_reg.flt[PIN_IOR];
  assign iow_act  = !r_reg.flt[PIN_IOW];
  assign memr_act = !r_reg.flt[PIN_MEMR];
  assign memw_act = !r_reg.flt[PIN_MEMW];
  assign io_hit   = aen_ok && (f_sa[9:IO_WIN_LSB] == io_base[9:IO_WIN_LSB]);
  // Data port window; the decode looks only at address lines and address enable
  assign io16_hit = io_hit && (f_sa[4:3] == IO16_OFS); // RULE_08
  assign mem_hit  = (f_sa[BROM_LSB +: BROM_W] == brom_base);
  // Twelve bits decoded, so bit 10 must read zero for a match
  assign pnp_a_hit = aen_ok && (f_sa[11:0] == PNP_ADDR_PORT); // RULE_10
  assign pnp_d_hit = aen_ok && (f_sa[11:0] == PNP_DATA_PORT); // RULE_10

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next     = r_reg;
    r_next.s1  = pins_now;
    r_next.s2  = r_reg.s1;
    r_next.s3  = r_reg.s2;
    // A bit moves only once the second and third stages agree
    r_next.flt = (r_reg.s2 & r_reg.s3) | (r_reg.flt & (r_reg.s2 ^ r_reg.s3));

    r_next.ior_prev  = ior_act;
    r_next.iow_prev  = iow_act;
    r_next.memw_prev = memw_act;

    if (rst_if.bus_rst_release) begin
      r_next.is16 = r_reg.flt[PIN_SLOT]; // RULE_06
    end

    r_next.irq_oe    = IRQ_N'(1) << irq_select; // RULE_03
    r_next.irq_drive = {IRQ_N{irq_request}} & r_next.irq_oe;
    r_next.irq_level = IRQ_LEVEL[irq_select]; // RULE_02
    r_next.irq_mon   = r_reg.flt[PIN_IRQ_LSB +: IRQ_N]; // RULE_04

    r_next.io_rd = io_hit && ior_act && !r_reg.ior_prev; // RULE_01
    r_next.io_wr = io_hit && iow_act && !r_reg.iow_prev; // RULE_01
    r_next.pnp_addr_wr = pnp_a_hit && iow_act && !r_reg.iow_prev;
    r_next.pnp_data_wr = pnp_d_hit && iow_act && !r_reg.iow_prev;
    r_next.addr  = f_sa;
    // Eight-bit slot drops the upper lane so stray bus noise never leaks in
    r_next.wdata = r_next.is16 ? f_sd : {8'h00, f_sd[7:0]}; // RULE_13

    r_next.chrdy_oe = io_hit && (ior_act || iow_act) && !core_ready; // RULE_05

    // Lanes follow the width latched on this very edge, so a changed
    // strap never meets a decode that was made for the old width
    r_next.sd_drive = r_next.is16 ? rd_data : {8'h00, rd_data[7:0]};
    r_next.sd_oe_lo = io_hit && ior_act;
    r_next.sd_oe_hi = io16_hit && ior_act && r_next.is16; // RULE_13

    // Pin is released while reset lasts, so the strap can be sensed
    r_next.xfer16_oe = r_next.is16 && io16_hit; // RULE_07

    r_next.bms_n = !(mem_hit
                     && (memr_act || (memw_act && flash_wr_en))); // RULE_12
    r_next.flash_wr = mem_hit && flash_wr_en && memw_act
                      && !r_reg.memw_prev; // RULE_11

    if (rst_if.bus_rst_active) begin
      r_next.io_rd       = 1'b0;
      r_next.io_wr       = 1'b0;
      r_next.pnp_addr_wr = 1'b0;
      r_next.pnp_data_wr = 1'b0;
      r_next.flash_wr    = 1'b0;
      r_next.chrdy_oe    = 1'b0;
      r_next.sd_oe_lo    = 1'b0;
      r_next.sd_oe_hi    = 1'b0;
      r_next.xfer16_oe   = 1'b0;
      r_next.bms_n       = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r_reg           <= '0;
      r_reg.s1        <= PIN_IDLE;
      r_reg.s2        <= PIN_IDLE;
      r_reg.s3        <= PIN_IDLE;
      r_reg.flt       <= PIN_IDLE;
      r_reg.irq_oe    <= IRQ_OE_RST;
      r_reg.irq_level <= IRQ_LEVEL[0];
      r_reg.bms_n     <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sd_drive          = r_reg.sd_drive;
  assign sd_oe_lo          = r_reg.sd_oe_lo;
  assign sd_oe_hi          = r_reg.sd_oe_hi;
  assign irq_out_lines     = r_reg.irq_drive;
  assign irq_out_lines_oe  = r_reg.irq_oe;
  // Both open-drain pins only ever pull low; the enables do the work
  assign chrdy_drive       = r_reg.od_level;
  assign chrdy_oe          = r_reg.chrdy_oe;
  assign xfer16_drive      = r_reg.od_level;
  assign xfer16_oe         = r_reg.xfer16_oe;
  assign boot_mem_select_n = r_reg.bms_n;
  assign io_rd_pulse       = r_reg.io_rd;
  assign io_wr_pulse       = r_reg.io_wr;
  assign pnp_addr_wr       = r_reg.pnp_addr_wr;
  assign pnp_data_wr       = r_reg.pnp_data_wr;
  assign flash_wr_pulse    = r_reg.flash_wr;
  assign host_addr         = r_reg.addr;
  assign host_wdata        = r_reg.wdata;
  assign irq_line_monitor  = r_reg.irq_mon;
  assign irq_level         = r_reg.irq_level;
  assign slot_is_16        = r_reg.is16;
  assign bus_reset_active  = rst_if.bus_rst_active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A pin level counts only after two equal samples, hence the lags below
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_aen_blocks_io: assert property ( // RULE_01
    !aen_ok |=> !io_rd_pulse && !io_wr_pulse && !sd_oe_lo && !chrdy_oe)
    else $error("I/O command taken while address enable high");

  a_irq_line_map: assert property ( // RULE_02
    ##1 (irq_out_lines_oe == (IRQ_N'(1) << $past(irq_select)))
        && (irq_level == IRQ_LEVEL[$past(irq_select)]))
    else $error("Request line does not follow selection");

  a_irq_one_line: assert property ( // RULE_03
    $onehot(irq_out_lines_oe) && ((irq_out_lines & ~irq_out_lines_oe) == '0))
    else $error("Unselected request line is driven");

  a_irq_monitor: assert property ( // RULE_04
    $changed(irq_out_lines_level) ##1 $stable(irq_out_lines_level) |-> ##4
      irq_line_monitor == $past(irq_out_lines_level, 4))
    else $error("Request line monitor does not track pins");

  a_irq_drive: assert property ( // RULE_03
    ##1 irq_out_lines == ({IRQ_N{$past(irq_request)}} & irq_out_lines_oe))
    else $error("Request line does not carry the device request");

  a_chrdy_wait: assert property ( // RULE_05
    (io_hit && (ior_act || iow_act) && !core_ready
     && !rst_if.bus_rst_active) |=> chrdy_oe && !chrdy_drive)
    else $error("Wait state not inserted while core busy");

  a_chrdy_release: assert property ( // RULE_05
    core_ready |=> !chrdy_oe)
    else $error("Channel ready held after core became ready");

  a_slot_latch: assert property ( // RULE_06
    rst_if.bus_rst_release |=> slot_is_16 == $past(r_reg.flt[PIN_SLOT]))
    else $error("Slot width not latched at end of bus reset");

  a_xfer16_decode: assert property ( // RULE_08
    (io16_hit && slot_is_16 && !rst_if.bus_rst_active
     && !rst_if.bus_rst_release) |=> xfer16_oe)
    else $error("16-bit indication waits for a strobe");

  a_xfer16_slot8: assert property ( // RULE_13
    !slot_is_16 |-> !xfer16_oe && !sd_oe_hi)
    else $error("Upper lane used in 8-bit slot");

  a_xfer16_reset: assert property ( // RULE_07
    rst_if.bus_rst_active |=> !xfer16_oe)
    else $error("Slot pin driven during bus reset");

  a_pnp_decode: assert property ( // RULE_10
    pnp_data_wr || pnp_addr_wr |->
      !$past(f_sa[10]) && !$past(r_reg.flt[PIN_AEN]))
    else $error("Plug-and-play port hit with bit 10 set");

  a_flash_write: assert property ( // RULE_11
    flash_wr_pulse |-> $past(flash_wr_en) && $past(mem_hit)
      && !boot_mem_select_n)
    else $error("Flash write outside window or disabled");

  a_boot_select: assert property ( // RULE_12
    (!mem_hit || (!memr_act && !memw_act)) |=> boot_mem_select_n)
    else $error("Boot memory selected without match and strobe");

  a_io_pulse_once: assert property ( // RULE_01
    io_rd_pulse || io_wr_pulse |=> !io_rd_pulse && !io_wr_pulse)
    else $error("I/O command accepted twice");

  a_low_lane_only: assert property ( // RULE_13
    !slot_is_16 |-> host_wdata[15:8] == 8'h00 && sd_drive[15:8] == 8'h00)
    else $error("Upper data byte carried in 8-bit slot");

  a_busrst_quiet: assert property ( // RULE_09
    bus_reset_active |=> !io_rd_pulse && !io_wr_pulse && !flash_wr_pulse
      && !sd_oe_lo && boot_mem_select_n)
    else $error("Bus command taken during bus reset");

  c_io_read_wait: cover property (
    io_rd_pulse ##[1:5] chrdy_oe ##[1:20] !chrdy_oe);
  c_slot_width_sense_sense: cover property (rst_if.bus_rst_release ##1 slot_is_16);
  c_flash_wr:     cover property (flash_wr_pulse);
  c_pnp_write:    cover property (pnp_addr_wr ##[1:50] pnp_data_wr);
endmodule

// ==== bench/ihbi_host_model.sv ====
// ISA host model: drives address, enable, strobes and write data.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module ihbi_host_model (
  input  wire logic                  clock,
  input  wire logic                  chrdy_oe,
  output logic                       aen,
  output logic                       ior_n,
  output logic                       iow_n,
  output logic                       smemr_n,
  output logic                       smemw_n,
  output logic [ihbi_pkg::SA_W-1:0]  sa,
  output logic [ihbi_pkg::SD_W-1:0]  sd_level
);
  import ihbi_pkg::*;

  initial begin
    aen = 1'b1;
    {smemw_n, smemr_n, iow_n, ior_n} = 4'hF;
    sa = '0;
    sd_level = '0;
  end

  task automatic set_addr(input logic en, input logic [19:0] a);
    @(posedge clock);
    #1;
    aen = en;
    sa = a;
  endtask

  // Kind 0..3: I/O read, I/O write, memory read, memory write
  task automatic cycle(input int kind, input logic en,
                       input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    set_addr(en, a);
    sd_level = d;
    @(posedge clock);
    #1;
    {smemw_n, smemr_n, iow_n, ior_n} = ~(4'h1 << kind);
    repeat (8) @(posedge clock);
    #1;
    // Bounded wait so a stuck ready line cannot hang the host
    while (chrdy_oe === 1'b1 && n < 60) begin
      @(posedge clock);
      #1;
      n++;
    end
    {smemw_n, smemr_n, iow_n, ior_n} = 4'hF;
    repeat (6) @(posedge clock);
    #1;
    // Released lines show a changed pattern, never the last value
    sd_level = ~d;
    aen = 1'b1;
    sa = ~a;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the ISA host bus interface core.
// Assumes a 10 MHz clock and the host model on the bus side.
`timescale 1ns/1ps
module testbench;
  import ihbi_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        bus_reset = 1'b0;
  logic        slot_pull = 1'b0;
  logic        flash_wr_en = 1'b0;
  logic        core_ready = 1'b1;
  logic        irq_request = 1'b0;
  logic [2:0]  irq_select = 3'h0;
  logic [7:0]  irq_ext = 8'hFF;
  wire         aen, ior_n, iow_n, smemr_n, smemw_n, chrdy_oe, xfer16_oe;
  wire [19:0]  sa, host_addr;
  wire [15:0]  sd_level, sd_drive, host_wdata;
  wire [7:0]   irq_out_lines, irq_out_lines_oe, irq_line_monitor;
  wire [3:0]   irq_level;
  wire         io_rd_pulse, io_wr_pulse, pnp_addr_wr, pnp_data_wr;
  wire         flash_wr_pulse, boot_mem_select_n, slot_is_16;
  wire         bus_reset_active, sd_oe_lo, sd_oe_hi, chrdy_drive;
  wire         xfer16_drive;
  wire         slot_width_sense;
  wire [7:0]   irq_wire;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          cnt [7];

  // Open-drain pin and request lines resolved from every driver
  assign slot_width_sense = xfer16_oe ? 1'b0 : slot_pull;
  assign irq_wire = (irq_out_lines_oe & irq_out_lines) |
                    (~irq_out_lines_oe & irq_ext);

  ihbi_host_model host (.clock(clock), .chrdy_oe(chrdy_oe), .aen(aen),
    .ior_n(ior_n), .iow_n(iow_n), .smemr_n(smemr_n), .smemw_n(smemw_n),
    .sa(sa), .sd_level(sd_level));

  ihbi_core dut (.clock(clock), .nrst(nrst), .bus_reset(bus_reset),
    .aen(aen), .ior_n(ior_n), .iow_n(iow_n), .smemr_n(smemr_n),
    .smemw_n(smemw_n), .sa(sa), .sd_level(sd_level), .sd_drive(sd_drive),
    .sd_oe_lo(sd_oe_lo), .sd_oe_hi(sd_oe_hi),
    .irq_out_lines_level(irq_wire),
    .irq_out_lines(irq_out_lines), .irq_out_lines_oe(irq_out_lines_oe),
    .chrdy_drive(chrdy_drive), .chrdy_oe(chrdy_oe),
    .slot_width_sense(slot_width_sense), .xfer16_drive(xfer16_drive),
    .xfer16_oe(xfer16_oe), .boot_mem_select_n(boot_mem_select_n),
    .io_base(10'h300), .brom_base(6'h32), .flash_wr_en(flash_wr_en),
    .irq_select(irq_select), .irq_request(irq_request),
    .core_ready(core_ready), .rd_data(16'h5A3C),
    .io_rd_pulse(io_rd_pulse), .io_wr_pulse(io_wr_pulse),
    .pnp_addr_wr(pnp_addr_wr), .pnp_data_wr(pnp_data_wr),
    .flash_wr_pulse(flash_wr_pulse), .host_addr(host_addr),
    .host_wdata(host_wdata),
    .irq_line_monitor(irq_line_monitor), .irq_level(irq_level),
    .slot_is_16(slot_is_16), .bus_reset_active(bus_reset_active));

  always #50 clock = ~clock;

  // -------------------------------------------------------------
  // Event counters and shared tasks
  // -------------------------------------------------------------
  always @(posedge clock) begin
    cnt[0] += int'(io_rd_pulse === 1'b1);
    cnt[1] += int'(io_wr_pulse === 1'b1);
    cnt[2] += int'(pnp_addr_wr === 1'b1);
    cnt[3] += int'(pnp_data_wr === 1'b1);
    cnt[4] += int'(flash_wr_pulse === 1'b1);
    cnt[5] += int'(boot_mem_select_n === 1'b0);
    cnt[6] += int'(bus_reset_active === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic clear();
    foreach (cnt[i]) cnt[i] = 0;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_slot8();
    slot_pull = 1'b1;
    host.set_addr(1'b0, 20'h00310);
    step(6);
    check(xfer16_oe, 0);
    check(slot_is_16, 0);
    host.cycle(1, 1'b0, 20'h00300, 16'h1234);
    check(host_wdata, 16'h0034);
    check(sd_drive, 16'h003C);
  endtask

  task automatic t_busrst();
    host.set_addr(1'b1, 20'h00000);
    clear();
    bus_reset = 1'b1;
    step(7);
    bus_reset = 1'b0;
    step(14);
    check(cnt[6], 0);
    bus_reset = 1'b1;
    step(14);
    check(bus_reset_active, 1);
    bus_reset = 1'b0;
    step(6);
    check(bus_reset_active, 0);
    check(slot_is_16, 1);
    host.set_addr(1'b0, 20'h00310);
    step(6);
    check(xfer16_oe, 1);
    check(xfer16_drive, 0);
    host.set_addr(1'b1, 20'h00310);
    step(6);
    check(xfer16_oe, 0);
  endtask

  task automatic t_irq();
    logic [3:0] lvl [8] = '{4'h9, 4'h3, 4'h4, 4'h5, 4'hA, 4'hB, 4'hC, 4'hF};
    irq_request = 1'b1;
    for (int i = 0; i < 8; i++) begin
      irq_select = 3'(i);
      step(2);
      check(irq_out_lines_oe, 8'h01 << i);
      check(irq_out_lines, 8'h01 << i);
      check(irq_level, lvl[i]);
    end
    irq_request = 1'b0;
    irq_ext = 8'hA5;
    step(8);
    check(irq_line_monitor, 8'h25);
  endtask

  task automatic t_io();
    clear();
    core_ready = 1'b0;
    fork
      host.cycle(0, 1'b0, 20'h00310, 16'h0000);
      begin
        step(9);
        check(chrdy_oe, 1);
        check(sd_oe_lo, 1);
        check(sd_oe_hi, 1);
        check(sd_drive, 16'h5A3C);
        check(xfer16_oe, 1);
        check(chrdy_drive, 0);
        core_ready = 1'b1;
      end
    join
    check(chrdy_oe, 0);
    host.cycle(1, 1'b0, 20'h00300, 16'h1234);
    check(host_wdata, 16'h1234);
    check(host_addr, 20'h00300);
    host.cycle(0, 1'b1, 20'h00308, 16'h0000);
    host.cycle(1, 1'b1, 20'h00300, 16'h4321);
    check(cnt[0], 1);
    check(cnt[1], 1);
  endtask

  task automatic t_pnp();
    clear();
    host.cycle(1, 1'b0, 20'h00279, 16'h0011);
    host.cycle(1, 1'b0, 20'h00A79, 16'h0022);
    host.cycle(1, 1'b0, 20'h00679, 16'h0033);
    host.cycle(1, 1'b1, 20'h00279, 16'h0044);
    check(cnt[2], 1);
    check(cnt[3], 1);
  endtask

  task automatic t_flash();
    clear();
    host.cycle(3, 1'b1, 20'hC8010, 16'h00AB);
    check(cnt[5], 0);
    flash_wr_en = 1'b1;
    host.cycle(3, 1'b1, 20'hC8010, 16'h00CD);
    host.cycle(3, 1'b1, 20'hD0010, 16'h00EF);
    check(cnt[4], 1);
    check(cnt[5] != 0, 1);
    clear();
    host.cycle(2, 1'b1, 20'hC8020, 16'h0000);
    check(cnt[5] != 0, 1);
    check(cnt[4], 0);
  endtask

  initial begin
    repeat (2) @(posedge clock);
    #1;
    nrst = 1'b1;
    step(2);
    check(irq_out_lines_oe, 8'h01);
    check(boot_mem_select_n, 1);
    t_slot8();
    t_busrst();
    t_irq();
    t_io();
    t_pnp();
    t_flash();
    results();
  end
endmodule
